//--- hw/scs_top.sv
// Purpose: sysref capture, skew windows, status, counter and sync mode control
// Assumes: sysref_i and sample_i synchronous to clk_i; classic wishbone slave
// Notes:   every output comes from a flip-flop
// How it works
// - positive window tolerates up to 0..3 clocks of late sysref
// - negative window tolerates up to 0..3 clocks of early sysref
// - timestamp mark delayed by programmable 0..127 sample clocks
// - read-only divider phase at capture, half input clock steps
// - 8-bit event counter increments per capture, wraps after 255
// - flag-reset bit clears the event counter
// - setup and hold flags held clear while flag-reset bit is one
// - divider-reset mode resets dividers on each accepted sysref
// - divider-reset mode drops link when a divider phase must change
// - timestamp mode leaves dividers and link alone
// - timestamp mode marks a sample as a control bit in output word
`timescale 1ns/10ps
module scs_top #(
  parameter int DIV_LEN  = scs_pkg::DIV_LEN_DEF,
  parameter int SAMPLE_W = 16
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [11:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                sysref_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic      [SAMPLE_W:0]   word_o,
  output logic                     ts_mark_o,
  output logic                     div_reset_o,
  output logic                     link_down_o,
  output logic                     irq_o
);
  generate
    if (SAMPLE_W < 1 || SAMPLE_W > 31)
    begin : g_bad
      $error("scs_top: SAMPLE_W must be 1..31");
    end
  endgenerate

  localparam logic [2:0] DIV_L = 3'(DIV_LEN);

  localparam int TS_LEN_M1 = scs_pkg::TS_DELAY_MAX - 1;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  window_reg;
  logic [6:0]  tsdly_reg;
  logic [7:0]  sync_reg;
  logic [7:0]  shstat_reg;
  logic [3:0]  phase_reg;
  logic [7:0]  count_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_mask_reg;
  logic        nshot_armed_reg;
  logic        sysref_q_reg;
  logic [TS_LEN_M1:0] ts_line_reg;
  scs_pkg::scs_bus_t bus_reg;

  logic [2:0]  div_cnt;
  logic [3:0]  div_phase;
  logic        flag_rst;
  logic        ts_mode;
  logic [1:0]  win_pos;
  logic [1:0]  win_neg;
  logic        cap_en;
  logic        cap;
  logic [2:0]  early;
  logic        in_win;
  logic        div_rst_next;
  logic        link_next;
  logic        mark_next;
  logic        req;
  logic        wr;
  logic [9:0]  idx;
  logic [2:0]  irq_set;

  // divider count and phase feed the capture logic

  scs_divider #(
    .DIV_LEN (DIV_LEN)
  ) u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sync_i  (div_rst_next),
    .cnt_o   (div_cnt),
    .phase_o (div_phase)
  );

  assign flag_rst = ctrl1_reg[scs_pkg::CTRL1_FLAG_RST_BIT];
  assign ts_mode  = sync_reg[scs_pkg::SYNC_MODE_BIT];
  assign win_pos  = window_reg[scs_pkg::WIN_POS_LSB +: 2];
  assign win_neg  = window_reg[scs_pkg::WIN_NEG_LSB +: 2];
  assign idx      = wb_adr_i[11:2];
  assign req      = wb_cyc_i && wb_stb_i && (bus_reg == scs_pkg::BUS_IDLE);
  assign wr       = req && wb_we_i && wb_sel_i[0];

  // capture gating by mode select
  always_comb
  begin
    case (scs_pkg::scs_mode_t'(ctrl1_reg[scs_pkg::CTRL1_MODE_LSB +: 2]))
      scs_pkg::MODE_CONTINUOUS: cap_en = 1'b1;
      scs_pkg::MODE_NSHOT:      cap_en = nshot_armed_reg;
      default:                  cap_en = 1'b0;
    endcase
  end

  assign cap    = sysref_i && !sysref_q_reg && cap_en;
  assign early  = DIV_L - div_cnt;
  // late by div_cnt clocks, or early by early clocks
  assign in_win = (div_cnt != 3'h0) &&
                  ((div_cnt <= {1'b0, win_pos}) ||
                   (early <= {1'b0, win_neg}));
  assign div_rst_next = cap && !ts_mode && !in_win;
  assign link_next    = div_rst_next && (div_cnt != 3'h0);
  assign mark_next    = (tsdly_reg == 7'h00) ? (cap && ts_mode)
                                             : ts_line_reg[tsdly_reg - 7'h1];
  assign irq_set      = {mark_next, link_next, cap};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sysref_q_reg <= 1'b0;
    else
      sysref_q_reg <= sysref_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ts_line_reg <= '0;
    else
      ts_line_reg <= {ts_line_reg[TS_LEN_M1-1:0], cap && ts_mode};
  end

  // output word with timestamp control bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_o    <= '0;
      ts_mark_o <= 1'b0;
    end
    else
    begin
      word_o    <= {mark_next, sample_i};
      ts_mark_o <= mark_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_reset_o <= 1'b0;
      link_down_o <= 1'b0;
    end
    else
    begin
      div_reset_o <= div_rst_next;
      link_down_o <= link_next;
    end
  end

  // capture status
  always_ff @(posedge clk_i)
  begin
    if (rst_i || flag_rst)
      shstat_reg <= 8'h00;
    else if (cap)
      shstat_reg <= {1'b0, div_cnt, (div_cnt == 3'h0) ? 4'h0 : {1'b0, early}};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      phase_reg <= 4'h0;
    else if (cap)
      phase_reg <= div_phase;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || flag_rst)
      count_reg <= 8'h00;
    else if (cap)
      count_reg <= count_reg + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nshot_armed_reg <= 1'b0;
    else if (wr && idx == scs_pkg::IDX_CTRL1)
      nshot_armed_reg <= 1'b1;
    else if (cap)
      nshot_armed_reg <= 1'b0;
  end

  // software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl1_reg    <= scs_pkg::CTRL1_RST;
      window_reg   <= scs_pkg::WINDOW_RST;
      tsdly_reg    <= scs_pkg::TSDLY_RST;
      sync_reg     <= scs_pkg::SYNC_RST;
      irq_mask_reg <= scs_pkg::IRQ_MASK_RST;
    end
    else if (wr)
    begin
      if (idx == scs_pkg::IDX_CTRL1)
        ctrl1_reg <= wb_dat_i[7:0] & 8'h46;
      else if (idx == scs_pkg::IDX_WINDOW)
        window_reg <= {4'h0, wb_dat_i[3:0]};
      else if (idx == scs_pkg::IDX_TSDLY)
        tsdly_reg <= wb_dat_i[6:0];
      else if (idx == scs_pkg::IDX_SYNC)
        sync_reg <= {7'h00, wb_dat_i[0]};
      else if (idx == scs_pkg::IDX_IRQ_MASK)
        irq_mask_reg <= wb_dat_i[2:0];
    end
  end

  // sticky events, set wins over write-one clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= 3'h0;
    else if (wr && idx == scs_pkg::IDX_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[2:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_reg  <= scs_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      case (bus_reg)
        scs_pkg::BUS_IDLE:
        begin
          wb_ack_o <= req;
          if (req)
            bus_reg <= scs_pkg::BUS_ACK;
        end
        scs_pkg::BUS_ACK:
        begin
          wb_ack_o <= 1'b0;
          bus_reg  <= scs_pkg::BUS_IDLE;
        end
        default:
        begin
          wb_ack_o <= 1'b0;
          bus_reg  <= scs_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // read data; counter is only coherent with capture disabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (req && !wb_we_i)
    begin
      if (idx == scs_pkg::IDX_CTRL1)
        wb_dat_o <= {24'h0, ctrl1_reg};
      else if (idx == scs_pkg::IDX_WINDOW)
        wb_dat_o <= {24'h0, window_reg};
      else if (idx == scs_pkg::IDX_TSDLY)
        wb_dat_o <= {25'h0, tsdly_reg};
      else if (idx == scs_pkg::IDX_SHSTAT)
        wb_dat_o <= {24'h0, shstat_reg};
      else if (idx == scs_pkg::IDX_PHASE)
        wb_dat_o <= {28'h0, phase_reg};
      else if (idx == scs_pkg::IDX_COUNT)
        wb_dat_o <= {24'h0, count_reg};
      else if (idx == scs_pkg::IDX_SYNC)
        wb_dat_o <= {24'h0, sync_reg};
      else if (idx == scs_pkg::IDX_IRQ_STAT)
        wb_dat_o <= {29'h0, irq_stat_reg};
      else if (idx == scs_pkg::IDX_IRQ_MASK)
        wb_dat_o <= {29'h0, irq_mask_reg};
      else
        wb_dat_o <= 32'h0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_window_pos_ok: assert property (
    cap && !ts_mode && div_cnt != 3'h0 && div_cnt <= {1'b0, win_pos} |=> !div_reset_o)
    else $error("late sysref inside window reset dividers");
  chk_window_neg_ok: assert property (
    cap && !ts_mode && div_cnt != 3'h0 && early <= {1'b0, win_neg} |=> !link_down_o)
    else $error("early sysref inside window dropped link");
  chk_ts_delay_two: assert property (
    cap && ts_mode && tsdly_reg == 7'h02 && !wr |-> ##3 ts_mark_o)
    else $error("timestamp mark not delayed by two cycles");
  chk_phase_capture: assert property (
    cap |=> phase_reg == $past(div_phase))
    else $error("divider phase not captured");
  chk_count_step: assert property (
    cap && !flag_rst |=> count_reg == $past(count_reg) + 8'h01)
    else $error("event counter did not step");
  chk_count_clear: assert property (
    flag_rst |=> count_reg == 8'h00)
    else $error("event counter not cleared by flag reset");
  chk_flags_held: assert property (
    flag_rst |=> shstat_reg == 8'h00)
    else $error("setup/hold flags not held clear");
  chk_div_reset: assert property (
    cap && !ts_mode && !in_win |=> div_reset_o ##1 div_cnt == 3'h1)
    else $error("divider not reset by accepted sysref");
  chk_link_drop: assert property (
    cap && !ts_mode && !in_win && div_cnt != 3'h0 |=> link_down_o)
    else $error("link not dropped on phase change");
  chk_ts_quiet: assert property (
    ts_mode && cap |=> !div_reset_o && !link_down_o)
    else $error("timestamp mode disturbed dividers or link");
  chk_mark_in_word: assert property (
    ts_mark_o |-> word_o[SAMPLE_W])
    else $error("mark missing from output word");
  chk_bus_ack: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle after request");

  cov_ts_mark:   cover property (cap && ts_mode ##1 ts_line_reg[0]);
  cov_link_down: cover property (link_down_o);
  cov_wrap:      cover property (cap && count_reg == 8'hff);
  cov_irq:       cover property (irq_o);
endmodule // scs_top

//--- pkg/scs_pkg.sv
// Purpose: shared constants for the sysref capture and sync control block
// Assumes: register index n sits at wishbone byte address 4*n
// Notes:   8-bit registers sit in the low byte of each word
package scs_pkg;
  // register indices
  localparam logic [9:0] IDX_CTRL1    = 10'h120;
  localparam logic [9:0] IDX_WINDOW   = 10'h122;
  localparam logic [9:0] IDX_TSDLY    = 10'h123;
  localparam logic [9:0] IDX_SHSTAT   = 10'h128;
  localparam logic [9:0] IDX_PHASE    = 10'h129;
  localparam logic [9:0] IDX_COUNT    = 10'h12a;
  localparam logic [9:0] IDX_SYNC     = 10'h1ff;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h130;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h131;

  // field positions
  localparam int CTRL1_FLAG_RST_BIT = 6;
  localparam int CTRL1_MODE_LSB     = 1;
  localparam int WIN_POS_LSB        = 0;
  localparam int WIN_NEG_LSB        = 2;
  localparam int SYNC_MODE_BIT      = 0;
  localparam int HOLD_LSB           = 4;
  localparam int IRQ_EVENT_BIT      = 0;
  localparam int IRQ_LINK_BIT       = 1;
  localparam int IRQ_MARK_BIT       = 2;
  localparam int IRQ_W              = 3;

  // reset values
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] WINDOW_RST = 8'h00;
  localparam logic [6:0] TSDLY_RST  = 7'h00;
  localparam logic [7:0] SYNC_RST   = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // timing
  localparam int TS_DELAY_MAX = 127;
  localparam int DIV_LEN_DEF  = 8;

  typedef enum logic [1:0] {
    MODE_DISABLED   = 2'h0,
    MODE_CONTINUOUS = 2'h1,
    MODE_NSHOT      = 2'h2
  } scs_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } scs_bus_t;
endpackage

//--- hw/scs_divider.sv
// Purpose: sample clock divider whose phase the sysref logic samples and resets
// Assumes: one count per sample clock
// Notes:   phase code is the count in half input clock steps
`timescale 1ns/10ps
module scs_divider #(
  parameter int DIV_LEN = scs_pkg::DIV_LEN_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sync_i,
  output logic [2:0]      cnt_o,
  output logic [3:0]      phase_o
);
  generate
    if (DIV_LEN < 2 || DIV_LEN > 8)
    begin : g_bad
      $error("scs_divider: DIV_LEN must be 2..8");
    end
  endgenerate

  localparam logic [2:0] LAST = 3'(DIV_LEN - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || sync_i)
      cnt_o <= 3'h0;
    else if (cnt_o == LAST)
      cnt_o <= 3'h0;
    else
      cnt_o <= cnt_o + 3'h1;
  end

  assign phase_o = {cnt_o, 1'b0};
endmodule // scs_divider

//--- verification/scs_sysref_src.sv
// Purpose: far-side source of sysref pulses and a running sample stream
// Assumes: one fire request gives one single-cycle sysref pulse
// Notes:   lag_i delays the pulse by 0..3 clocks; samples change every cycle
`timescale 1ns/10ps
module scs_sysref_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        fire_i,
  input  wire logic [1:0]  lag_i,
  output logic             sysref_o,
  output logic [15:0]      sample_o
);
  logic [2:0] dly_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dly_reg  <= 3'h0;
      sysref_o <= 1'b0;
      sample_o <= 16'h0;
    end
    else
    begin
      dly_reg  <= {dly_reg[1:0], fire_i};
      sysref_o <= (lag_i == 2'h0) ? fire_i : dly_reg[lag_i - 2'h1];
      sample_o <= sample_o + 16'h1;
    end
  end
endmodule // scs_sysref_src

//--- verification/scs_top_tb_top.sv
// Purpose: self-checking bench for the sysref capture and sync block
// Assumes: register index n at byte address 4*n, low byte only
// Notes:   counter is read only with capture mode disabled
`timescale 1ns/10ps
module scs_top_tb_top;
  typedef struct packed {logic w; logic [9:0] idx; logic [7:0] d; logic [7:0] e;} scs_row_t;
  logic        clk_i, rst_i, cyc, stb, we, fire, sysref, ack, ts_mark, div_rst, link_dn, irq;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, q, rd;
  logic [1:0]  lag;
  logic [15:0] smp;
  logic [16:0] word;
  logic [7:0]  h;
  int          n_mismatch, n_compared, cyc_n, jts, ndr, nld;
  int          dl [4] = '{0, 2, 5, 127};
  scs_row_t    rows [16] = '{
    '{0, scs_pkg::IDX_CTRL1, 8'h00, 8'h00}, '{0, scs_pkg::IDX_WINDOW, 8'h00, 8'h00},
    '{0, scs_pkg::IDX_TSDLY, 8'h00, 8'h00}, '{0, scs_pkg::IDX_SHSTAT, 8'h00, 8'h00},
    '{0, scs_pkg::IDX_PHASE, 8'h00, 8'h00}, '{0, scs_pkg::IDX_COUNT, 8'h00, 8'h00},
    '{0, scs_pkg::IDX_SYNC, 8'h00, 8'h00}, '{1, scs_pkg::IDX_TSDLY, 8'hff, 8'h00},
    '{0, scs_pkg::IDX_TSDLY, 8'h00, 8'h7f}, '{1, scs_pkg::IDX_SYNC, 8'hff, 8'h00},
    '{0, scs_pkg::IDX_SYNC, 8'h00, 8'h01}, '{1, scs_pkg::IDX_WINDOW, 8'h0f, 8'h00},
    '{0, scs_pkg::IDX_WINDOW, 8'h00, 8'h0f}, '{1, scs_pkg::IDX_SHSTAT, 8'hff, 8'h00},
    '{0, scs_pkg::IDX_SHSTAT, 8'h00, 8'h00}, '{0, 10'h3ff, 8'h00, 8'h00}};

  scs_top scs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .sysref_i(sysref), .sample_i(smp), .word_o(word),
    .ts_mark_o(ts_mark), .div_reset_o(div_rst), .link_down_o(link_dn), .irq_o(irq));
  scs_sysref_src scs_sysref_src_inst (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .lag_i(lag), .sysref_o(sysref), .sample_o(smp));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    rd = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // one sysref pulse; counts edges from capture to the first mark, and the cycles each reset output is high
  task automatic ev(input int n);
    int t;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (sysref !== 1'b1 && t < 8);
    chk(sysref, 1'b1);
    jts = 0;
    ndr = 0;
    nld = 0;
    for (int j = 1; j <= n; j++)
    begin
      @(posedge clk_i);
      if (ts_mark === 1'b1 && jts == 0) jts = j;
      if (ts_mark === 1'b1) chk(word[16], 1'b1);
      if (j == 1) chk(word[15:0], 16'(smp - 16'h1));
      ndr += int'(div_rst === 1'b1);
      nld += int'(link_dn === 1'b1);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end

  initial
  begin
    {rst_i, cyc, stb, we, fire, adr, sel, dat, lag} = {1'b1, 54'h0};
    {n_mismatch, n_compared, cyc_n} = 96'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
      wb(rows[i].w, rows[i].idx, rows[i].d);
      if (!rows[i].w) chk(rd, {24'h0, rows[i].e});
    end
    // timestamp mode, continuous capture
    wb(1'b1, scs_pkg::IDX_SYNC, 8'h01);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h02);
    foreach (dl[i])
    begin
      wb(1'b1, scs_pkg::IDX_TSDLY, 8'(dl[i]));
      ev(140);
      chk(jts, dl[i] + 1);
      chk(ndr + nld, 0);
    end
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h00);
    rdchk(scs_pkg::IDX_COUNT, 8'h04);
    ev(2);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h02);
    repeat (252) ev(2);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h00);
    rdchk(scs_pkg::IDX_COUNT, 8'h00);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h02);
    ev(2);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h00);
    rdchk(scs_pkg::IDX_COUNT, 8'h01);
    // divider-reset mode at many phases, windows closed then wide
    wb(1'b1, scs_pkg::IDX_SYNC, 8'h00);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h02);
    for (int w = 0; w < 2; w++)
    begin
      wb(1'b1, scs_pkg::IDX_WINDOW, (w == 1) ? 8'h0f : 8'h00);
      for (int i = 0; i < 8; i++)
      begin
        lag <= i[1:0];
        repeat (i) @(posedge clk_i);
        ev(4);
        wb(1'b0, scs_pkg::IDX_PHASE, 8'h00);
        h = {5'h0, rd[3:1]};
        chk(rd[0], 1'b0);
        rdchk(scs_pkg::IDX_SHSTAT, {h[3:0], (h == 8'h0) ? 4'h0 : 4'h8 - h[3:0]});
        chk(ndr, (w == 0) || (h == 8'h0) || (h == 8'h4));
        chk(nld, (ndr == 1) && (h != 8'h0));
      end
    end
    lag <= 2'h0;
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h40);
    rdchk(scs_pkg::IDX_COUNT, 8'h00);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h42);
    ev(4);
    rdchk(scs_pkg::IDX_SHSTAT, 8'h00);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h40);
    // interrupt raised, masked, unmasked, cleared
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h02);
    wb(1'b1, scs_pkg::IDX_IRQ_STAT, 8'h07);
    ev(4);
    wb(1'b0, scs_pkg::IDX_IRQ_STAT, 8'h00);
    chk(rd[0], 1'b1);
    chk(irq, 1'b0);
    wb(1'b1, scs_pkg::IDX_IRQ_MASK, 8'h01);
    @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b1, scs_pkg::IDX_IRQ_STAT, 8'h01);
    @(posedge clk_i);
    chk(irq, 1'b0);
    // n-shot takes one event per control write
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h04);
    ev(4);
    ev(4);
    wb(1'b1, scs_pkg::IDX_CTRL1, 8'h00);
    rdchk(scs_pkg::IDX_COUNT, 8'h02);
    end_of_test;
  end
endmodule // scs_top_tb_top
